// file: design/urm_pkg.sv
// Shared constants and types for the redriver mode and configuration block.
package urm_pkg;

  localparam longint CLK_HZ        = 40_000_000;
  localparam longint RST_PW_MIN_US = 100;
  // Least low time on the disable pin, rounded up to whole cycles.
  localparam int unsigned RST_PW_CYC =
    int'((RST_PW_MIN_US * CLK_HZ + 64'd999_999) / 64'd1_000_000);

  localparam logic [6:0] DEV_ADDR = 7'h2C;

  localparam logic [7:0] OFS_TRANS  = 8'h01;
  localparam logic [7:0] OFS_CFG    = 8'h03;
  localparam logic [7:0] OFS_STATIC = 8'h0E;
  localparam logic [7:0] OFS_GAIN   = 8'h25;

  localparam int unsigned TRANS_LSB  = 4;
  localparam int unsigned STATIC_LSB = 0;
  localparam int unsigned CFG_BIT    = 0;

  // Hardware-set values for the reserved parts of the transition, static and configuration registers, and for the configuration bit.
  localparam logic [3:0] TRANS_RSVD_RST  = 4'h0;
  localparam logic [3:0] STATIC_RSVD_RST = 4'h0;
  localparam logic [6:0] CFG_RSVD_RST    = 7'h00;
  localparam logic       CFG_ACTIVE_RST  = 1'b1;

  localparam logic [3:0] TRANS_LVL0 = 4'h0;
  localparam logic [3:0] TRANS_LVL1 = 4'h3;
  localparam logic [3:0] TRANS_LVL2 = 4'h6;
  localparam logic [3:0] TRANS_LVL3 = 4'h8;

  localparam logic [3:0] STATIC_LVL0  = 4'h0;
  localparam logic [3:0] STATIC_LVL12 = 4'h2;
  localparam logic [3:0] STATIC_LVL3  = 4'h6;

  localparam logic [7:0] GAIN_CODE_LOW  = 8'h00;
  localparam logic [7:0] GAIN_CODE_MID  = 8'h44;
  localparam logic [7:0] GAIN_CODE_HIGH = 8'h77;

  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  typedef enum logic [1:0] {
    GAIN_SEL_LOW  = 2'h0,
    GAIN_SEL_MID  = 2'h1,
    GAIN_SEL_HIGH = 2'h2
  } urm_gain_sel_t;

  typedef enum logic [5:0] {
    MODE_SHUTDOWN = 6'h01,
    MODE_DISCONN  = 6'h02,
    MODE_LOWFULL  = 6'h04,
    MODE_HIGH     = 6'h08,
    MODE_COMPLY   = 6'h10,
    MODE_CFG_HOLD = 6'h20
  } urm_mode_t;

endpackage

// file: design/urm_serial_target.sv
// Two-wire serial target that turns bus transfers into byte register accesses.
module urm_serial_target
  import urm_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       reset,
  input  wire logic       enable,
  input  wire logic       scl_s,
  input  wire logic       sda_s,
  output logic            sda_oe,
  output logic            wr_stb,
  output logic [7:0]      wr_addr,
  output logic [7:0]      wr_data,
  output logic [7:0]      rd_addr,
  input  wire logic [7:0] rd_data
);

  typedef enum logic [6:0] {
    ST_IDLE   = 7'h01,
    ST_ADDR   = 7'h02,
    ST_ACK_A  = 7'h04,
    ST_WR     = 7'h08,
    ST_ACK_W  = 7'h10,
    ST_RD     = 7'h20,
    ST_RD_ACK = 7'h40
  } urm_st_t;

  urm_st_t    state_r;
  logic       scl_q_r;
  logic       sda_q_r;
  logic [3:0] cnt_r;
  logic [7:0] shift_r;
  logic [7:0] ptr_r;
  logic       rw_r;
  logic       first_r;
  logic       acked_r;
  logic       start_c;
  logic       stop_c;
  logic       rise_c;
  logic       fall_c;

  assign start_c = scl_s & scl_q_r & sda_q_r & ~sda_s;
  assign stop_c  = scl_s & scl_q_r & ~sda_q_r & sda_s;
  assign rise_c  = scl_s & ~scl_q_r;
  assign fall_c  = ~scl_s & scl_q_r;
  assign rd_addr = ptr_r;
  assign wr_addr = ptr_r;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
    end else begin
      scl_q_r <= scl_s;
      sda_q_r <= sda_s;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset || !enable) begin
      state_r <= ST_IDLE;
      cnt_r   <= 4'h0;
      shift_r <= 8'h00;
      ptr_r   <= 8'h00;
      rw_r    <= 1'b0;
      first_r <= 1'b0;
      acked_r <= 1'b0;
      sda_oe  <= 1'b0;
      wr_stb  <= 1'b0;
      wr_data <= 8'h00;
    end else begin
      wr_stb <= 1'b0;
      if (start_c) begin
        state_r <= ST_ADDR;
        cnt_r   <= 4'h0;
        sda_oe  <= 1'b0;
      end else if (stop_c) begin
        state_r <= ST_IDLE;
        sda_oe  <= 1'b0;
      end else begin
        unique case (state_r)
          ST_IDLE: begin
          end
          ST_ADDR, ST_WR: begin
            if (rise_c && cnt_r != 4'h8) begin
              shift_r <= {shift_r[6:0], sda_s};
              cnt_r   <= cnt_r + 4'h1;
            end else if (fall_c && cnt_r == 4'h8) begin
              if (state_r == ST_ADDR) begin
                if (shift_r[7:1] == DEV_ADDR) begin
                  sda_oe  <= 1'b1;
                  rw_r    <= shift_r[0];
                  state_r <= ST_ACK_A;
                end else begin
                  state_r <= ST_IDLE;
                end
              end else begin
                sda_oe  <= 1'b1;
                state_r <= ST_ACK_W;
                if (first_r) begin
                  ptr_r <= shift_r;
                end else begin
                  wr_stb  <= 1'b1;
                  wr_data <= shift_r;
                end
              end
            end
          end
          ST_ACK_A: begin
            if (fall_c) begin
              cnt_r <= 4'h0;
              if (rw_r) begin
                sda_oe  <= ~rd_data[7];
                shift_r <= {rd_data[6:0], 1'b0};
                cnt_r   <= 4'h1;
                state_r <= ST_RD;
              end else begin
                sda_oe  <= 1'b0;
                first_r <= 1'b1;
                state_r <= ST_WR;
              end
            end
          end
          ST_ACK_W: begin
            if (fall_c) begin
              sda_oe  <= 1'b0;
              cnt_r   <= 4'h0;
              state_r <= ST_WR;
              first_r <= 1'b0;
              // In writes the offset advances after each data byte, not after the offset byte.
              if (!first_r) begin
                ptr_r <= ptr_r + 8'h01;
              end
            end
          end
          ST_RD: begin
            if (fall_c) begin
              if (cnt_r == 4'h8) begin
                sda_oe  <= 1'b0;
                ptr_r   <= ptr_r + 8'h01;
                state_r <= ST_RD_ACK;
              end else begin
                sda_oe  <= ~shift_r[7];
                shift_r <= {shift_r[6:0], 1'b0};
                cnt_r   <= cnt_r + 4'h1;
              end
            end
          end
          ST_RD_ACK: begin
            if (rise_c) begin
              acked_r <= ~sda_s;
            end else if (fall_c) begin
              if (acked_r) begin
                sda_oe  <= ~rd_data[7];
                shift_r <= {rd_data[6:0], 1'b0};
                cnt_r   <= 4'h1;
                state_r <= ST_RD;
              end else begin
                state_r <= ST_IDLE;
              end
            end
          end
          default: begin
            state_r <= ST_IDLE;
          end
        endcase
      end
    end
  end

endmodule

// file: design/urm_mode_config.sv
// Mode control, strap sampling and configuration registers of the redriver.

module urm_mode_config
  import urm_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       reset,
  input  wire logic       chip_disable_n,
  input  wire logic       scl_i,
  output logic            scl_o,
  output logic            scl_oe,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe,
  output logic            hs_pin_o,
  output logic            hs_pin_oe,
  input  wire logic [1:0] boost_strap,
  input  wire logic [1:0] receive_gain_select,
  input  wire logic       dp_pullup,
  input  wire logic       dm_pullup,
  input  wire logic       hs_handshake_ok,
  input  wire logic       fixture_detect,
  input  wire logic       disconnect_detect,
  output logic            attach_detected_flag,
  output logic            highspeed_active_flag,
  output logic            compensation_en,
  output logic            eye_test_mode,
  output logic            serial_mode,
  output logic [3:0]      transition_emphasis_code,
  output logic [3:0]      static_emphasis_code,
  output logic [7:0]      receive_gain_code
);

  localparam int unsigned NSYNC = 12;

  logic [NSYNC-1:0] sync1_r;
  logic [NSYNC-1:0] sync2_r;
  logic             en_s;
  logic             scl_s;
  logic             sda_s;
  logic             dp_s;
  logic             dm_s;
  logic             hs_ok_s;
  logic             fixture_s;
  logic             disc_s;
  logic [1:0]       boost_s;
  urm_gain_sel_t    gain_s;

  urm_mode_t        mode_r;
  urm_mode_t        mode_nxt;
  logic [11:0]      low_cnt_r;
  logic             low_valid;
  logic             hs_resume_r;
  logic             release_c;
  logic             serial_nxt;

  logic [7:0]       trans_reg_r;
  logic [7:0]       cfg_reg_r;
  logic [7:0]       static_reg_r;
  logic [7:0]       gain_reg_r;
  logic [3:0]       trans_strap;
  logic [3:0]       static_strap;
  logic [7:0]       gain_strap;

  logic             wr_stb;
  logic [7:0]       wr_addr;
  logic [7:0]       wr_data;
  logic [7:0]       rd_addr;
  logic [7:0]       rd_data;
  logic             bus_sda_oe;

  // Every pin-level input is brought onto ref_clk through two flops.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= {chip_disable_n, scl_i, sda_i, dp_pullup, dm_pullup,
                  hs_handshake_ok, fixture_detect, disconnect_detect,
                  boost_strap, receive_gain_select};
      sync2_r <= sync1_r;
    end
  end

  assign en_s      = sync2_r[11];
  assign scl_s     = sync2_r[10];
  assign sda_s     = sync2_r[9];
  assign dp_s      = sync2_r[8];
  assign dm_s      = sync2_r[7];
  assign hs_ok_s   = sync2_r[6];
  assign fixture_s = sync2_r[5];
  assign disc_s    = sync2_r[4];
  assign boost_s   = sync2_r[3:2];
  assign gain_s    = urm_gain_sel_t'(sync2_r[1:0]);

  // Qualify disable width.
  // Short glitches on the disable pin are ignored, so a bouncing line
  // cannot knock a live link out of high speed.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      low_cnt_r <= 12'h000;
    end else if (en_s) begin
      low_cnt_r <= 12'h000;
    end else if (low_cnt_r != 12'(RST_PW_CYC)) begin
      low_cnt_r <= low_cnt_r + 12'h001;
    end
  end

  assign low_valid = (low_cnt_r == 12'(RST_PW_CYC));
  // Release waits until the width counter has cleared, so the mode
  // decision still sees the high-speed resume flag from the shutdown.
  assign release_c = (mode_r == MODE_SHUTDOWN) && en_s && !low_valid;
  // Both bus lines high selects serial mode.
  assign serial_nxt = scl_s & sda_s;

  always_comb begin
    unique case (boost_s)
      2'h0: begin
        trans_strap  = TRANS_LVL0;
        static_strap = STATIC_LVL0;
      end
      2'h1: begin
        trans_strap  = TRANS_LVL1;
        static_strap = STATIC_LVL12;
      end
      2'h2: begin
        trans_strap  = TRANS_LVL2;
        static_strap = STATIC_LVL12;
      end
      2'h3: begin
        trans_strap  = TRANS_LVL3;
        static_strap = STATIC_LVL3;
      end
    endcase
  end

  always_comb begin
    unique case (gain_s)
      GAIN_SEL_LOW:  gain_strap = GAIN_CODE_LOW;
      GAIN_SEL_MID:  gain_strap = GAIN_CODE_MID;
      GAIN_SEL_HIGH: gain_strap = GAIN_CODE_HIGH;
      default:       gain_strap = GAIN_CODE_MID;
    endcase
  end

  always_comb begin
    mode_nxt = mode_r;
    if (low_valid) begin
      mode_nxt = MODE_SHUTDOWN;
    end else begin
      unique case (mode_r)
        MODE_SHUTDOWN: begin
          if (en_s) begin
            if (hs_resume_r) begin
              mode_nxt = MODE_COMPLY;
            end else if (serial_nxt && CFG_ACTIVE_RST) begin
              mode_nxt = MODE_CFG_HOLD;
            end else begin
              mode_nxt = MODE_DISCONN;
            end
          end
        end
        MODE_DISCONN: begin
          if (fixture_s) begin
            mode_nxt = MODE_COMPLY;
          end else if (dp_s || dm_s) begin
            mode_nxt = MODE_LOWFULL;
          end
        end
        MODE_LOWFULL: begin
          if (disc_s) begin
            mode_nxt = MODE_DISCONN;
          end else if (hs_ok_s) begin
            mode_nxt = MODE_HIGH;
          end
        end
        MODE_HIGH, MODE_COMPLY: begin
          if (disc_s) begin
            mode_nxt = MODE_DISCONN;
          end
        end
        MODE_CFG_HOLD: begin
          if (!cfg_reg_r[CFG_BIT]) begin
            mode_nxt = MODE_DISCONN;
          end
        end
        default: mode_nxt = MODE_SHUTDOWN;
      endcase
      if (serial_mode && cfg_reg_r[CFG_BIT] && mode_r != MODE_SHUTDOWN) begin
        mode_nxt = MODE_CFG_HOLD;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      mode_r      <= MODE_SHUTDOWN;
      hs_resume_r <= 1'b0;
      serial_mode <= 1'b0;
    end else begin
      mode_r <= mode_nxt;
      if (mode_r == MODE_HIGH && mode_nxt == MODE_SHUTDOWN) begin
        hs_resume_r <= 1'b1;
      end else if (release_c) begin
        hs_resume_r <= 1'b0;
      end
      if (release_c) begin
        serial_mode <= serial_nxt;
      end
    end
  end

  // Mode flags and compensation controls come from flops.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      attach_detected_flag  <= 1'b0;
      highspeed_active_flag <= 1'b0;
      compensation_en       <= 1'b0;
      eye_test_mode         <= 1'b0;
    end else begin
      attach_detected_flag  <= (mode_nxt == MODE_LOWFULL) ||
                               (mode_nxt == MODE_HIGH);
      highspeed_active_flag <= (mode_nxt == MODE_HIGH) ||
                               (mode_nxt == MODE_COMPLY);
      compensation_en       <= (mode_nxt == MODE_HIGH) ||
                               (mode_nxt == MODE_COMPLY);
      eye_test_mode         <= (mode_nxt == MODE_COMPLY);
    end
  end

  // Strap mode pin use.
  // The shared pins stay undriven in shutdown so the bus straps can be
  // read cleanly on release.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      scl_oe    <= 1'b0;
      hs_pin_oe <= 1'b0;
    end else begin
      scl_oe    <= (mode_nxt != MODE_SHUTDOWN) &&
                   !(release_c ? serial_nxt : serial_mode);
      hs_pin_oe <= (mode_nxt != MODE_SHUTDOWN) &&
                   !(release_c ? serial_nxt : serial_mode);
    end
  end

  assign scl_o    = attach_detected_flag;
  assign hs_pin_o = highspeed_active_flag;
  assign sda_o    = 1'b0;
  assign sda_oe   = bus_sda_oe;

  assign transition_emphasis_code = trans_reg_r[TRANS_LSB +: 4];
  assign static_emphasis_code     = static_reg_r[STATIC_LSB +: 4];
  assign receive_gain_code        = gain_reg_r;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      trans_reg_r  <= 8'h00;
      static_reg_r <= 8'h00;
      gain_reg_r   <= 8'h00;
      cfg_reg_r    <= {CFG_RSVD_RST, CFG_ACTIVE_RST};
    end else if (release_c) begin
      trans_reg_r  <= {trans_strap, TRANS_RSVD_RST};
      static_reg_r <= {STATIC_RSVD_RST, static_strap};
      gain_reg_r   <= gain_strap;
      cfg_reg_r    <= {CFG_RSVD_RST, CFG_ACTIVE_RST};
    end else if (wr_stb && serial_mode) begin
      unique case (wr_addr)
        OFS_TRANS:  trans_reg_r  <= wr_data;
        OFS_CFG:    cfg_reg_r    <= wr_data;
        OFS_STATIC: static_reg_r <= wr_data;
        OFS_GAIN:   gain_reg_r   <= wr_data;
        default:    trans_reg_r  <= trans_reg_r;
      endcase
    end
  end

  always_comb begin
    unique case (rd_addr)
      OFS_TRANS:  rd_data = trans_reg_r;
      OFS_CFG:    rd_data = cfg_reg_r;
      OFS_STATIC: rd_data = static_reg_r;
      OFS_GAIN:   rd_data = gain_reg_r;
      default:    rd_data = UNMAPPED_READ;
    endcase
  end

  urm_serial_target u_target (
    .ref_clk (ref_clk),
    .reset   (reset),
    .enable  (serial_mode && mode_r != MODE_SHUTDOWN),
    .scl_s   (scl_s),
    .sda_s   (sda_s),
    .sda_oe  (bus_sda_oe),
    .wr_stb  (wr_stb),
    .wr_addr (wr_addr),
    .wr_data (wr_data),
    .rd_addr (rd_addr),
    .rd_data (rd_data)
  );

endmodule

// file: sim/urm_mode_config_props.sv
// Checker of flag, pin and mode relations at the mode control ports.
module urm_mode_config_props
  import urm_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic chip_disable_n,
  input wire logic scl_o,
  input wire logic scl_oe,
  input wire logic hs_pin_o,
  input wire logic hs_pin_oe,
  input wire logic dp_pullup,
  input wire logic dm_pullup,
  input wire logic disconnect_detect,
  input wire logic attach_detected_flag,
  input wire logic highspeed_active_flag,
  input wire logic compensation_en,
  input wire logic eye_test_mode,
  input wire logic serial_mode
);
  localparam int SHUT_CYC = RST_PW_CYC + 5;
  logic        dis_q_r;
  logic [15:0] run_cnt_r;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  // Cycles since the disable pin last changed, saturating.
  always_ff @(posedge ref_clk) begin
    dis_q_r <= chip_disable_n;
    if (reset || chip_disable_n != dis_q_r) begin
      run_cnt_r <= 16'h0000;
    end else if (run_cnt_r != 16'hFFFF) begin
      run_cnt_r <= run_cnt_r + 16'h0001;
    end
  end
  shut_flags_a: assert property (
    !chip_disable_n && run_cnt_r >= SHUT_CYC |-> !attach_detected_flag
      && !highspeed_active_flag && !compensation_en)
    else $error("flags not low in shutdown");
  hs_comp_a: assert property (
    highspeed_active_flag |-> compensation_en)
    else $error("high speed without compensation");
  slow_no_comp_a: assert property (
    attach_detected_flag && !highspeed_active_flag |-> !compensation_en)
    else $error("compensation on in slow mode");
  eye_flags_a: assert property (
    eye_test_mode |-> highspeed_active_flag && !attach_detected_flag)
    else $error("eye test flags wrong");
  comply_comp_a: assert property (
    eye_test_mode |-> compensation_en)
    else $error("eye test without compensation");
  attach_pin_a: assert property (
    scl_oe |-> !serial_mode && scl_o == attach_detected_flag)
    else $error("clock pin not showing attach");
  hs_pin_a: assert property (
    hs_pin_oe |-> hs_pin_o == highspeed_active_flag)
    else $error("sensitivity pin not showing high speed");
  disc_drop_a: assert property (
    (disconnect_detect && !dp_pullup && !dm_pullup) [*5]
      |-> !attach_detected_flag && !highspeed_active_flag)
    else $error("flags kept after disconnect");
  serial_latch_a: assert property (
    !$stable(serial_mode) |-> (chip_disable_n && run_cnt_r <= 16'h0006)
      || (!chip_disable_n && run_cnt_r >= RST_PW_CYC - 1))
    else $error("serial mode changed away from release");
endmodule

bind urm_mode_config urm_mode_config_props u_props (
  .ref_clk(ref_clk), .reset(reset), .chip_disable_n(chip_disable_n),
  .scl_o(scl_o), .scl_oe(scl_oe), .hs_pin_o(hs_pin_o),
  .hs_pin_oe(hs_pin_oe), .dp_pullup(dp_pullup), .dm_pullup(dm_pullup),
  .disconnect_detect(disconnect_detect),
  .attach_detected_flag(attach_detected_flag),
  .highspeed_active_flag(highspeed_active_flag),
  .compensation_en(compensation_en), .eye_test_mode(eye_test_mode),
  .serial_mode(serial_mode));

// file: sim/urm_bus_host.sv
// Two-wire bus host model that reaches the block's byte registers.
module urm_bus_host (
  input  wire logic ref_clk,
  input  wire logic sda_line,
  output logic      scl_low,
  output logic      sda_low
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [6:0] TGT_ADDR = 7'h2C;
  // Quarter bit in clocks; kept short but well above the pin synchronisers.
  localparam int QTR = 10;
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic hold_sda(input logic v);
    @(posedge ref_clk);
    sda_low <= v;
  endtask
  // Works from idle and as a repeated start with the clock held low.
  task automatic start_cond();
    sda_low <= 1'b0;
    tick(QTR);
    scl_low <= 1'b0;
    tick(QTR);
    sda_low <= 1'b1;
    tick(QTR);
    scl_low <= 1'b1;
    tick(QTR);
  endtask
  task automatic stop_cond();
    sda_low <= 1'b1;
    tick(QTR);
    scl_low <= 1'b0;
    tick(QTR);
    sda_low <= 1'b0;
    tick(2 * QTR);
  endtask
  task automatic xfer_bit(input logic tx, output logic rx);
    sda_low <= !tx;
    tick(QTR);
    scl_low <= 1'b0;
    tick(QTR);
    @(negedge ref_clk);
    rx = sda_line;
    tick(QTR);
    scl_low <= 1'b1;
    tick(QTR);
  endtask
  task automatic xfer_byte(input logic [7:0] tx, input logic ack_tx,
                           output logic [7:0] rx, output logic ack_rx);
    logic a;
    for (int i = 7; i >= 0; i--) begin
      xfer_bit(tx[i], rx[i]);
    end
    xfer_bit(ack_tx, a);
    ack_rx = !a;
  endtask
  task automatic write_reg(input logic [6:0] adr, input logic [7:0] ofs,
                           input logic [7:0] dat, output logic ok);
    logic [7:0] r;
    logic [2:0] a;
    start_cond();
    xfer_byte({adr, 1'b0}, 1'b1, r, a[0]);
    xfer_byte(ofs, 1'b1, r, a[1]);
    xfer_byte(dat, 1'b1, r, a[2]);
    stop_cond();
    ok = &a;
  endtask
  task automatic read_reg(input logic [7:0] ofs, output logic [7:0] dat,
                          output logic ok);
    logic [7:0] r;
    logic [2:0] a;
    logic       n;
    start_cond();
    xfer_byte({TGT_ADDR, 1'b0}, 1'b1, r, a[0]);
    xfer_byte(ofs, 1'b1, r, a[1]);
    start_cond();
    xfer_byte({TGT_ADDR, 1'b1}, 1'b1, r, a[2]);
    // A released acknowledge ends the read after one byte.
    xfer_byte(8'hFF, 1'b1, dat, n);
    stop_cond();
    ok = &a;
  endtask
endmodule

// file: sim/tb_usb_redriver_mode_config.sv
// Self-checking bench for the redriver mode and configuration block.
`define CHECK(got, want) \
  begin \
    num_checks++; \
    if ((got) !== (want)) begin \
      mismatches++; \
      $display("mismatch at %0t: got %0h want %0h", $time, (got), (want)); \
    end \
  end
module tb_usb_redriver_mode_config;
  timeunit 1ns;
  timeprecision 100ps;
  logic        ref_clk, reset, chip_disable_n, dp_pullup, dm_pullup;
  logic        hs_handshake_ok, fixture_detect, disconnect_detect;
  logic [1:0]  boost_strap, receive_gain_select;
  logic        scl_o, scl_oe, sda_o, sda_oe, hs_pin_o, hs_pin_oe;
  logic        attach_detected_flag, highspeed_active_flag;
  logic        compensation_en, eye_test_mode, serial_mode;
  logic [3:0]  transition_emphasis_code, static_emphasis_code;
  logic [7:0]  receive_gain_code;
  logic        scl_low, sda_low;
  logic [15:0] exp_v;
  logic [31:0] lfsr;
  int          mismatches, num_checks, cyc;
  wire scl_line = !scl_low && (!scl_oe || scl_o);
  wire sda_line = !sda_low && (!sda_oe || sda_o);

  urm_mode_config dut_u (
    .ref_clk(ref_clk), .reset(reset), .chip_disable_n(chip_disable_n),
    .scl_i(scl_line), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_line),
    .sda_o(sda_o), .sda_oe(sda_oe), .hs_pin_o(hs_pin_o),
    .hs_pin_oe(hs_pin_oe), .boost_strap(boost_strap),
    .receive_gain_select(receive_gain_select), .dp_pullup(dp_pullup),
    .dm_pullup(dm_pullup), .hs_handshake_ok(hs_handshake_ok),
    .fixture_detect(fixture_detect), .disconnect_detect(disconnect_detect),
    .attach_detected_flag(attach_detected_flag),
    .highspeed_active_flag(highspeed_active_flag),
    .compensation_en(compensation_en), .eye_test_mode(eye_test_mode),
    .serial_mode(serial_mode),
    .transition_emphasis_code(transition_emphasis_code),
    .static_emphasis_code(static_emphasis_code),
    .receive_gain_code(receive_gain_code));
  urm_bus_host u_host (.ref_clk(ref_clk), .sda_line(sda_line),
    .scl_low(scl_low), .sda_low(sda_low));

  function automatic logic [31:0] lfsr_next(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic logic [15:0] exp_codes(input logic [1:0] b, g);
    logic [3:0] tr [4] = '{4'h0, 4'h3, 4'h6, 4'h8};
    logic [3:0] st [4] = '{4'h0, 4'h2, 4'h2, 4'h6};
    logic [7:0] gn [4] = '{8'h00, 8'h44, 8'h77, 8'h44};
    return {tr[b], st[b], gn[g]};
  endfunction
  task automatic wait_clk(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic pulse_off(input int n, input logic [1:0] b, g,
                           input logic ser);
    dp_pullup <= 1'b0;
    dm_pullup <= 1'b0;
    hs_handshake_ok <= 1'b0;
    chip_disable_n <= 1'b0;
    wait_clk(n);
    `CHECK({attach_detected_flag, highspeed_active_flag}, 2'b00)
    boost_strap <= b;
    receive_gain_select <= g;
    u_host.hold_sda(!ser);
    chip_disable_n <= 1'b1;
    wait_clk(20);
    u_host.hold_sda(1'b0);
    `CHECK(serial_mode, ser)
  endtask
  task automatic rd_chk(input logic [7:0] ofs, want);
    logic [7:0] d;
    logic       ok;
    u_host.read_reg(ofs, d, ok);
    `CHECK({ok, d}, {1'b1, want})
  endtask
  task automatic wr_chk(input logic [6:0] adr, input logic [7:0] ofs, dat,
                        input logic want);
    logic ok;
    u_host.write_reg(adr, ofs, dat, ok);
    `CHECK(ok, want)
  endtask
  task automatic chk_flags(input logic [3:0] want);
    wait_clk(10);
    `CHECK({attach_detected_flag, highspeed_active_flag, compensation_en,
            eye_test_mode}, want)
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  // A hung handshake still ends the run with a verdict.
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 90000) begin
      mismatches++;
      complete_run();
    end
  end
  initial begin
    {reset, chip_disable_n, dp_pullup, dm_pullup} = 4'h8;
    {hs_handshake_ok, fixture_detect, disconnect_detect} = 3'h0;
    boost_strap = 2'h0;
    receive_gain_select = 2'h0;
    lfsr = 32'h0001_123D;
    wait_clk(2);
    reset <= 1'b0;
    wait_clk(12000);
    for (int i = 0; i < 4; i++) begin
      lfsr = lfsr_next(lfsr);
      exp_v = exp_codes(i[1:0], i[1:0]);
      pulse_off(4100, i[1:0], i[1:0], 1'b0);
      dp_pullup <= lfsr[0];
      dm_pullup <= !lfsr[0];
      chk_flags(4'b1000);
      `CHECK({transition_emphasis_code, static_emphasis_code,
              receive_gain_code}, exp_v)
      `CHECK(scl_line, 1'b1)
      `CHECK({hs_pin_oe, hs_pin_o}, 2'b10)
    end
    hs_handshake_ok <= 1'b1;
    chk_flags(4'b1110);
    chip_disable_n <= 1'b0;
    wait_clk(3000);
    chip_disable_n <= 1'b1;
    chk_flags(4'b1110);
    pulse_off(4100, 2'h3, 2'h2, 1'b0);
    chk_flags(4'b0111);
    disconnect_detect <= 1'b1;
    chk_flags(4'b0000);
    disconnect_detect <= 1'b0;
    fixture_detect <= 1'b1;
    chk_flags(4'b0111);
    fixture_detect <= 1'b0;
    lfsr = lfsr_next(lfsr);
    exp_v = exp_codes(lfsr[1:0], lfsr[3:2]);
    pulse_off(4100, lfsr[1:0], lfsr[3:2], 1'b1);
    dp_pullup <= 1'b1;
    chk_flags(4'b0000);
    rd_chk(8'h03, 8'h01);
    rd_chk(8'h01, {exp_v[15:12], 4'h0});
    rd_chk(8'h0E, {4'h0, exp_v[11:8]});
    rd_chk(8'h25, exp_v[7:0]);
    rd_chk(8'h10, 8'h00);
    wr_chk(7'h2D, 8'h03, 8'h00, 1'b0);
    chk_flags(4'b0000);
    wr_chk(7'h2C, 8'h01, {lfsr[7:4], 4'h0}, 1'b1);
    wr_chk(7'h2C, 8'h0E, {4'h0, lfsr[11:8]}, 1'b1);
    wr_chk(7'h2C, 8'h25, lfsr[19:12], 1'b1);
    wait_clk(4);
    `CHECK({transition_emphasis_code, static_emphasis_code,
            receive_gain_code}, {lfsr[7:4], lfsr[11:8], lfsr[19:12]})
    rd_chk(8'h25, lfsr[19:12]);
    wr_chk(7'h2C, 8'h03, 8'h00, 1'b1);
    chk_flags(4'b1000);
    rd_chk(8'h03, 8'h00);
    complete_run();
  end
endmodule
